// ### irq_pkg.sv
package irq_pkg;
  localparam int NSRC = 11;
  localparam int NEVT = 11;
  localparam int SRCW = 4;
  localparam int CLKS_PER_MC = 12;

  localparam logic [7:0] TMR_EXT_CTRL_ADDR = 8'h88;
  localparam logic [7:0] PRIO_LO_ADDR      = 8'hb8;
  localparam logic [7:0] PRIO_HI_ADDR      = 8'hba;
  localparam logic [7:0] AUX_PRIO_HI_ADDR  = 8'hbb;
  localparam logic [7:0] AUX_PRIO_LO_ADDR  = 8'hbc;
  localparam logic [7:0] EXT_IRQ_CTRL_ADDR = 8'hc0;
  localparam logic [7:0] BASE_EN_ADDR      = 8'hc1;
  localparam logic [7:0] AUX_EN_ADDR       = 8'hc2;
  localparam logic [7:0] SRC_FLAG_ADDR     = 8'hc3;
  localparam logic [7:0] SPI_STATUS_ADDR   = 8'hc4;

  localparam logic [7:0] REG_RESET      = 8'h00;
  localparam logic [7:0] PRIO_LO_MASK   = 8'h3f;
  localparam logic [7:0] AUX_MASK       = 8'h07;
  localparam logic [7:0] BASE_EN_MASK   = 8'hbf;
  localparam logic [7:0] SRC_FLAG_MASK  = 8'h7f;
  localparam logic [7:0] SPI_MASK       = 8'hb0;

  // Timer and external 0/1 control
  localparam int TMR1_OVF_BIT = 7;
  localparam int TMR0_OVF_BIT = 5;
  localparam int EXT1_PEND_BIT = 3;
  localparam int EXT1_EDGE_BIT = 2;
  localparam int EXT0_PEND_BIT = 1;
  localparam int EXT0_EDGE_BIT = 0;
  // External 2/3 control
  localparam int EXT3_PRIO_LO_BIT = 7;
  localparam int EXT3_EN_BIT = 6;
  localparam int EXT3_PEND_BIT = 5;
  localparam int EXT3_EDGE_BIT = 4;
  localparam int EXT2_PRIO_LO_BIT = 3;
  localparam int EXT2_EN_BIT = 2;
  localparam int EXT2_PEND_BIT = 1;
  localparam int EXT2_EDGE_BIT = 0;
  localparam int EXT2_PRIO_HI_BIT = 6;
  localparam int EXT3_PRIO_HI_BIT = 7;
  localparam int GLOBAL_EN_BIT = 7;
  // Source flags and control
  localparam int TMR2_OVF_BIT = 0;
  localparam int UART_RX_BIT = 2;
  localparam int UART_TX_BIT = 3;
  localparam int WAKE_BIT = 4;
  localparam int BROWNOUT_BIT = 5;
  localparam int BO_RESET_SEL_BIT = 6;
  localparam int SPI_DONE_BIT = 7;
  localparam int SPI_OVR_BIT = 5;
  localparam int SPI_FAULT_BIT = 4;
  localparam int SPI_EN_BIT = 0;
  localparam int WAKE_EN_BIT = 1;
  localparam int BO_EN_BIT = 2;

  // Sources in natural order
  localparam int SRC_EXT0 = 0;
  localparam int SRC_TMR0 = 1;
  localparam int SRC_EXT1 = 2;
  localparam int SRC_TMR1 = 3;
  localparam int SRC_UART = 4;
  localparam int SRC_TMR2 = 5;
  localparam int SRC_EXT2 = 6;
  localparam int SRC_EXT3 = 7;
  localparam int SRC_SPI = 8;
  localparam int SRC_WAKE = 9;
  localparam int SRC_BO = 10;

  localparam int EV_TMR0 = 0;
  localparam int EV_TMR1 = 1;
  localparam int EV_TMR2_OVF = 2;
  localparam int EV_SPI_DONE = 8;
  localparam int EV_SPI_FAULT = 9;
  localparam int EV_SPI_OVR = 10;
endpackage : irq_pkg

// ### ext_pin_if.sv
`timescale 1ns/1ps
interface ext_pin_if;
  logic pin;
  logic tick;
  logic fall;
  logic low;
  modport det (input pin, input tick, output fall, output low);
  modport core (output pin, output tick, input fall, input low);
endinterface : ext_pin_if

// ### ext_pin_detect.sv
`timescale 1ns/1ps
module ext_pin_detect (
  input wire logic clk,
  input wire logic rst,
  ext_pin_if.det   bus
);
  typedef struct packed {
    logic sync1;
    logic sync2;
    logic samp;
    logic fall;
  } det_t;
  localparam det_t DET_RST = '{sync1: 1'b1, sync2: 1'b1, samp: 1'b1, fall: 1'b0};

  det_t st;
  det_t next_st;

  always_comb begin
    next_st = st;
    next_st.sync1 = bus.pin;
    next_st.sync2 = st.sync1;
    next_st.fall = 1'b0;
    if (bus.tick) begin
      next_st.samp = st.sync2;
      next_st.fall = st.samp & ~st.sync2;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st <= DET_RST;
    end else begin
      st <= next_st;
    end
  end

  assign bus.fall = st.fall;
  assign bus.low = ~st.samp;

  property p_fall_detect;
    @(posedge clk) disable iff (rst)
    bus.tick && st.samp && !st.sync2 |=> bus.fall ##1 !bus.fall;
  endproperty
  a_fall_detect: assert property (p_fall_detect) else $error("falling sample not flagged");
endmodule : ext_pin_detect

// ### prio_resolve.sv
`timescale 1ns/1ps
module prio_resolve #(
  parameter int N  = 11,
  parameter int IW = 4
) (
  input  wire logic [N-1:0]      req,
  input  wire logic [N-1:0][1:0] lvl,
  output logic                   valid,
  output logic [IW-1:0]          idx,
  output logic [1:0]             level
);
  always_comb begin
    valid = 1'b0;
    idx = '0;
    level = 2'h0;
    for (int i = N - 1; i >= 0; i--) begin
      if (req[i] && (!valid || lvl[i] >= level)) begin
        valid = 1'b1;
        idx = IW'(i);
        level = lvl[i];
      end
    end
  end
endmodule : prio_resolve

// ### interrupt_request_logic.sv
// Local design decision: the strobed register port.
`timescale 1ns/1ps
// Function
// - External interrupt control register is 8 bits, all zero after reset.
// - Bits 6 and 2 enable requests from external pins 3 and 2.
// - Bits 4 and 0 select level (0) or falling edge (1) for pins 3, 2.
// - Edge mode samples each machine cycle; high then low sets pending.
// - Edge pending stays set until software clears or service entry clears.
// - Pins 0 and 1 edge pending cleared by hardware at service entry.
// - Level mode pending follows inverted pin; service entry leaves it alone.
// - Pin still low after service raises a further request.
// - Pins 2 and 3 behave like 0 and 1, including service clearing.
// - Timer 0/1 overflow sets flags; service entry clears them.
// - Timer 2 overflow or event flags request; never cleared on service.
// - UART request is OR of rx and tx done; only software clears.
// - Wake timer overflow sets flag; requests when its enable is set.
// - Brown-out requests only if flag, reset select 0, enable 1.
// - Three SPI flags share one request under SPI enable.
// - Software may write every flag except level-mode pin pending; a written 1 requests like hardware.
// - Per-source enables, and global enable bit 7 masks everything.
// - A flag left set keeps requesting until software clears it.
// - Pins 2/3 priority: low bits 3/7 here, high bits 6/7 elsewhere.
// - Four levels from high and low bit, 11 the highest.
// - Only strictly higher level preempts; level 3 never preempted.
// - Equal level ties go by natural order, pin 0 first, brown-out last.
module interrupt_request_logic #(
  parameter int MC_CLKS = irq_pkg::CLKS_PER_MC
) (
  input  wire logic                      clk,
  input  wire logic                      rst,
  input  wire logic [7:0]                addr,
  input  wire logic [7:0]                wdata,
  input  wire logic                      wr,
  input  wire logic                      rd,
  output logic      [7:0]                rdata,
  input  wire logic [3:0]                ext_pin,
  input  wire logic [irq_pkg::NEVT-1:0]  hw_evt,
  input  wire logic                      svc_enter,
  input  wire logic [irq_pkg::SRCW-1:0]  svc_src,
  input  wire logic                      svc_exit,
  output logic                           irq_req,
  output logic      [irq_pkg::SRCW-1:0]  irq_src,
  output logic      [1:0]                irq_level
);
  import irq_pkg::*;

  typedef struct packed {
    logic [7:0]      tmr_ext_ctrl;
    logic [7:0]      ext_irq_ctrl_reg;
    logic [7:0]      prio_lo;
    logic [7:0]      prio_hi;
    logic [7:0]      aux_lo;
    logic [7:0]      aux_hi;
    logic [7:0]      base_en;
    logic [7:0]      aux_en;
    logic [7:0]      src_flag;
    logic [7:0]      spi;
    logic [3:0]      act;
    logic [7:0]      mc_cnt;
    logic            tick;
    logic [7:0]      rdata;
    logic            req;
    logic [SRCW-1:0] src;
    logic [1:0]      lvl;
  } core_t;

  core_t                 st;
  core_t                 next_st;
  logic [NSRC-1:0]       req;
  logic [NSRC-1:0][1:0]  lvl;
  logic [NSRC-1:0]       sclr;
  logic [3:0]            fall;
  logic [3:0]            low;
  logic                  win_valid;
  logic [SRCW-1:0]       win_idx;
  logic [1:0]            win_lvl;
  logic                  w_tec;
  logic                  w_xic;
  logic                  w_flag;
  logic                  w_spi;

  function automatic logic upd(input logic cur, input logic w, input logic wbit,
                               input logic clr, input logic set);
    return set | (~clr & (w ? wbit : cur));
  endfunction : upd

  // Hardware set wins over software write and service clear
  function automatic logic ext_flag(input logic edge_m, input logic cur, input logic w,
                                    input logic wbit, input logic clr, input logic f,
                                    input logic lo);
    return edge_m ? upd(cur, w, wbit, clr, f) : lo;
  endfunction : ext_flag

  // one-cycle pin holds are only guaranteed seen when held a full machine cycle
  for (genvar g = 0; g < 4; g++) begin : g_ext
    ext_pin_if u_if ();
    assign u_if.pin = ext_pin[g];
    assign u_if.tick = st.tick;
    assign fall[g] = u_if.fall;
    assign low[g] = u_if.low;
    ext_pin_detect u_det (
      .clk (clk),
      .rst (rst),
      .bus (u_if.det)
    );
  end

  assign w_tec = wr && (addr == TMR_EXT_CTRL_ADDR);
  assign w_xic = wr && (addr == EXT_IRQ_CTRL_ADDR);
  assign w_flag = wr && (addr == SRC_FLAG_ADDR);
  assign w_spi = wr && (addr == SPI_STATUS_ADDR);
  assign sclr = (svc_enter && (svc_src < SRCW'(NSRC))) ? (NSRC'(1) << svc_src) : '0;

  always_comb begin
    // level is {high bit, low bit}
    for (int i = 0; i < 6; i++) begin
      lvl[i] = {st.prio_hi[i], st.prio_lo[i]};
    end
    lvl[SRC_EXT2] = {st.prio_hi[EXT2_PRIO_HI_BIT], st.ext_irq_ctrl_reg[EXT2_PRIO_LO_BIT]};
    lvl[SRC_EXT3] = {st.prio_hi[EXT3_PRIO_HI_BIT], st.ext_irq_ctrl_reg[EXT3_PRIO_LO_BIT]};
    lvl[SRC_SPI] = {st.aux_hi[SPI_EN_BIT], st.aux_lo[SPI_EN_BIT]};
    lvl[SRC_WAKE] = {st.aux_hi[WAKE_EN_BIT], st.aux_lo[WAKE_EN_BIT]};
    lvl[SRC_BO] = {st.aux_hi[BO_EN_BIT], st.aux_lo[BO_EN_BIT]};
    // flags request for as long as they stay set
    req[SRC_EXT0] = st.tmr_ext_ctrl[EXT0_PEND_BIT];
    req[SRC_TMR0] = st.tmr_ext_ctrl[TMR0_OVF_BIT];
    req[SRC_EXT1] = st.tmr_ext_ctrl[EXT1_PEND_BIT];
    req[SRC_TMR1] = st.tmr_ext_ctrl[TMR1_OVF_BIT];
    // UART request ORs both done flags
    req[SRC_UART] = st.src_flag[UART_RX_BIT] | st.src_flag[UART_TX_BIT];
    req[SRC_TMR2] = st.src_flag[TMR2_OVF_BIT] | st.src_flag[TMR2_OVF_BIT + 1];
    req[SRC_EXT2] = st.ext_irq_ctrl_reg[EXT2_PEND_BIT] & st.ext_irq_ctrl_reg[EXT2_EN_BIT];
    req[SRC_EXT3] = st.ext_irq_ctrl_reg[EXT3_PEND_BIT] & st.ext_irq_ctrl_reg[EXT3_EN_BIT];
    req[SRC_SPI] = (st.spi[SPI_DONE_BIT] | st.spi[SPI_FAULT_BIT] | st.spi[SPI_OVR_BIT])
                   & st.aux_en[SPI_EN_BIT];
    req[SRC_WAKE] = st.src_flag[WAKE_BIT] & st.aux_en[WAKE_EN_BIT];
    // brown-out only when reset select is clear
    req[SRC_BO] = st.src_flag[BROWNOUT_BIT] & ~st.src_flag[BO_RESET_SEL_BIT]
                  & st.aux_en[BO_EN_BIT];
    for (int i = 0; i < 6; i++) begin
      req[i] = req[i] & st.base_en[i];
    end
    req = req & {NSRC{st.base_en[GLOBAL_EN_BIT]}};
  end

  prio_resolve #(
    .N  (NSRC),
    .IW (SRCW)
  ) u_resolve (
    .req   (req),
    .lvl   (lvl),
    .valid (win_valid),
    .idx   (win_idx),
    .level (win_lvl)
  );

  always_comb begin
    next_st = st;
    next_st.tick = 1'b0;
    next_st.mc_cnt = st.mc_cnt + 8'h01;
    if (st.mc_cnt == 8'(MC_CLKS - 1)) begin
      next_st.mc_cnt = 8'h00;
      next_st.tick = 1'b1;
    end
    // Plain register writes; flag bits are overridden below
    // software writes reach every flag except level-mode pin pending
    if (w_tec) next_st.tmr_ext_ctrl = wdata;
    if (w_xic) next_st.ext_irq_ctrl_reg = wdata;
    if (wr && addr == PRIO_LO_ADDR) next_st.prio_lo = wdata & PRIO_LO_MASK;
    if (wr && addr == PRIO_HI_ADDR) next_st.prio_hi = wdata;
    if (wr && addr == AUX_PRIO_LO_ADDR) next_st.aux_lo = wdata & AUX_MASK;
    if (wr && addr == AUX_PRIO_HI_ADDR) next_st.aux_hi = wdata & AUX_MASK;
    if (wr && addr == BASE_EN_ADDR) next_st.base_en = wdata & BASE_EN_MASK;
    if (wr && addr == AUX_EN_ADDR) next_st.aux_en = wdata & AUX_MASK;
    if (w_flag) next_st.src_flag = wdata & SRC_FLAG_MASK;
    if (w_spi) next_st.spi = wdata & SPI_MASK;
    // pins 0/1 cleared on service entry in edge mode
    // level mode tracks the inverted sample
    next_st.tmr_ext_ctrl[EXT0_PEND_BIT] = ext_flag(st.tmr_ext_ctrl[EXT0_EDGE_BIT],
      st.tmr_ext_ctrl[EXT0_PEND_BIT], w_tec, wdata[EXT0_PEND_BIT], sclr[SRC_EXT0],
      fall[0], low[0]);
    next_st.tmr_ext_ctrl[EXT1_PEND_BIT] = ext_flag(st.tmr_ext_ctrl[EXT1_EDGE_BIT],
      st.tmr_ext_ctrl[EXT1_PEND_BIT], w_tec, wdata[EXT1_PEND_BIT], sclr[SRC_EXT1],
      fall[1], low[1]);
    // a pin still low requests again
    next_st.ext_irq_ctrl_reg[EXT2_PEND_BIT] = ext_flag(st.ext_irq_ctrl_reg[EXT2_EDGE_BIT],
      st.ext_irq_ctrl_reg[EXT2_PEND_BIT], w_xic, wdata[EXT2_PEND_BIT], sclr[SRC_EXT2],
      fall[2], low[2]);
    next_st.ext_irq_ctrl_reg[EXT3_PEND_BIT] = ext_flag(st.ext_irq_ctrl_reg[EXT3_EDGE_BIT],
      st.ext_irq_ctrl_reg[EXT3_PEND_BIT], w_xic, wdata[EXT3_PEND_BIT], sclr[SRC_EXT3],
      fall[3], low[3]);
    // timer 0/1 flags set and service-cleared
    next_st.tmr_ext_ctrl[TMR0_OVF_BIT] = upd(st.tmr_ext_ctrl[TMR0_OVF_BIT], w_tec,
      wdata[TMR0_OVF_BIT], sclr[SRC_TMR0], hw_evt[EV_TMR0]);
    next_st.tmr_ext_ctrl[TMR1_OVF_BIT] = upd(st.tmr_ext_ctrl[TMR1_OVF_BIT], w_tec,
      wdata[TMR1_OVF_BIT], sclr[SRC_TMR1], hw_evt[EV_TMR1]);
    // timer 2, UART, wake, brown-out flags never service-cleared
    for (int k = 0; k < 6; k++) begin
      next_st.src_flag[k] = upd(st.src_flag[k], w_flag, wdata[k], 1'b0,
                                hw_evt[EV_TMR2_OVF + k]);
    end
    next_st.spi[SPI_DONE_BIT] = upd(st.spi[SPI_DONE_BIT], w_spi, wdata[SPI_DONE_BIT],
                                    1'b0, hw_evt[EV_SPI_DONE]);
    next_st.spi[SPI_FAULT_BIT] = upd(st.spi[SPI_FAULT_BIT], w_spi, wdata[SPI_FAULT_BIT],
                                     1'b0, hw_evt[EV_SPI_FAULT]);
    next_st.spi[SPI_OVR_BIT] = upd(st.spi[SPI_OVR_BIT], w_spi, wdata[SPI_OVR_BIT],
                                   1'b0, hw_evt[EV_SPI_OVR]);
    // Return retires the highest active level before a new entry marks its own
    if (svc_exit) begin
      for (int l = 0; l < 4; l++) begin
        if (st.act[l]) next_st.act = st.act & ~(4'h1 << l);
      end
    end
    if (sclr != '0) next_st.act[lvl[svc_src]] = 1'b1;
    // request only above every active level
    next_st.req = win_valid && ((st.act >> win_lvl) == 4'h0);
    next_st.src = win_idx;
    next_st.lvl = win_lvl;
    next_st.rdata = 8'h00;
    if (rd) begin
      if (addr == TMR_EXT_CTRL_ADDR) next_st.rdata = st.tmr_ext_ctrl;
      else if (addr == EXT_IRQ_CTRL_ADDR) next_st.rdata = st.ext_irq_ctrl_reg;
      else if (addr == PRIO_LO_ADDR) next_st.rdata = st.prio_lo;
      else if (addr == PRIO_HI_ADDR) next_st.rdata = st.prio_hi;
      else if (addr == AUX_PRIO_LO_ADDR) next_st.rdata = st.aux_lo;
      else if (addr == AUX_PRIO_HI_ADDR) next_st.rdata = st.aux_hi;
      else if (addr == BASE_EN_ADDR) next_st.rdata = st.base_en;
      else if (addr == AUX_EN_ADDR) next_st.rdata = st.aux_en;
      else if (addr == SRC_FLAG_ADDR) next_st.rdata = st.src_flag;
      else if (addr == SPI_STATUS_ADDR) next_st.rdata = st.spi;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign rdata = st.rdata;
  assign irq_req = st.req;
  assign irq_src = st.src;
  assign irq_level = st.lvl;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  property p_rst_clear;
    $fell(rst) |-> st.ext_irq_ctrl_reg == REG_RESET;
  endproperty
  a_rst_clear: assert property (p_rst_clear) else $error("control not clear after reset");

  property p_ext2_block;
    !st.ext_irq_ctrl_reg[EXT2_EN_BIT] |-> !req[SRC_EXT2];
  endproperty
  a_ext2_block: assert property (p_ext2_block) else $error("disabled pin 2 requested");

  property p_edge_set;
    st.ext_irq_ctrl_reg[EXT3_EDGE_BIT] && fall[3] |=> st.ext_irq_ctrl_reg[EXT3_PEND_BIT];
  endproperty
  a_edge_set: assert property (p_edge_set) else $error("pin 3 edge not latched");

  property p_level_follow;
    !st.ext_irq_ctrl_reg[EXT2_EDGE_BIT] && !$past(st.ext_irq_ctrl_reg[EXT2_EDGE_BIT])
      |-> st.ext_irq_ctrl_reg[EXT2_PEND_BIT] == $past(low[2]);
  endproperty
  a_level_follow: assert property (p_level_follow) else $error("level flag off pin");

  property p_ext0_clear;
    svc_enter && svc_src == SRCW'(SRC_EXT0) && st.tmr_ext_ctrl[EXT0_EDGE_BIT] && !fall[0]
      |=> !st.tmr_ext_ctrl[EXT0_PEND_BIT];
  endproperty
  a_ext0_clear: assert property (p_ext0_clear) else $error("pin 0 flag kept");

  property p_tmr0_clear;
    svc_enter && svc_src == SRCW'(SRC_TMR0) && !hw_evt[EV_TMR0]
      |=> !st.tmr_ext_ctrl[TMR0_OVF_BIT];
  endproperty
  a_tmr0_clear: assert property (p_tmr0_clear) else $error("timer 0 flag kept");

  property p_tmr2_keep;
    svc_enter && st.src_flag[TMR2_OVF_BIT] && !w_flag |=> st.src_flag[TMR2_OVF_BIT];
  endproperty
  a_tmr2_keep: assert property (p_tmr2_keep) else $error("timer 2 flag lost");

  property p_brownout;
    req[SRC_BO] |-> st.src_flag[BROWNOUT_BIT] && !st.src_flag[BO_RESET_SEL_BIT]
      && st.aux_en[BO_EN_BIT];
  endproperty
  a_brownout: assert property (p_brownout) else $error("brown-out request ungated");

  property p_global;
    !st.base_en[GLOBAL_EN_BIT] |=> !irq_req;
  endproperty
  a_global: assert property (p_global) else $error("request with global enable off");

  property p_preempt;
    irq_req |-> ($past(st.act) >> irq_level) == 4'h0;
  endproperty
  a_preempt: assert property (p_preempt) else $error("request not above active level");

  property p_ext3_block;
    !st.ext_irq_ctrl_reg[EXT3_EN_BIT] |=> !(irq_req && irq_src == SRCW'(SRC_EXT3));
  endproperty
  a_ext3_block: assert property (p_ext3_block) else $error("disabled pin 3 requested");

  property p_level_svc;
    svc_enter && svc_src == SRCW'(SRC_EXT2) && !st.ext_irq_ctrl_reg[EXT2_EDGE_BIT] && low[2]
      |=> st.ext_irq_ctrl_reg[EXT2_PEND_BIT];
  endproperty
  a_level_svc: assert property (p_level_svc) else $error("level flag cleared on entry");

  property p_uart_keep;
    svc_enter && svc_src == SRCW'(SRC_UART) && st.src_flag[UART_RX_BIT] && !w_flag
      |=> st.src_flag[UART_RX_BIT];
  endproperty
  a_uart_keep: assert property (p_uart_keep) else $error("uart flag lost");

  property p_spi_req;
    st.spi[SPI_FAULT_BIT] && st.aux_en[SPI_EN_BIT] && st.base_en[GLOBAL_EN_BIT]
      |-> req[SRC_SPI];
  endproperty
  a_spi_req: assert property (p_spi_req) else $error("spi fault not requesting");

  property p_soft_set;
    w_flag && wdata[UART_RX_BIT] |=> st.src_flag[UART_RX_BIT];
  endproperty
  a_soft_set: assert property (p_soft_set) else $error("written flag not set");
endmodule : interrupt_request_logic

// ### ext_requester.sv
`timescale 1ns/1ps
module ext_requester #(
  parameter int MC = 4
) (
  input  wire logic       clk,
  input  wire logic [3:0] lo_req,
  output logic      [3:0] pin
);
  // Pins start idle high so the synchroniser never sees a false edge
  logic [3:0] drv = 4'hf;
  int         hold [4] = '{0, 0, 0, 0};

  assign pin = drv;

  // two machine cycles
  // Each level is held two machine cycles so a late sample still sees it
  always @(posedge clk) begin
    for (int i = 0; i < 4; i++) begin
      if (hold[i] > 0) begin
        hold[i] <= hold[i] - 1;
      end else if (drv[i] == lo_req[i]) begin
        drv[i]  <= ~lo_req[i];
        hold[i] <= 2 * MC;
      end
    end
  end
endmodule : ext_requester

// ### tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import irq_pkg::*;
  localparam int MC = 4;
  localparam logic [7:0] AMAP [11] = '{8'h88, 8'hb8, 8'hba, 8'hbb, 8'hbc, 8'hc0,
                                       8'hc1, 8'hc2, 8'hc3, 8'hc4, 8'hc5};
  localparam logic [7:0] PA [4] = '{8'h88, 8'h88, 8'hc0, 8'hc0};
  localparam logic [7:0] PB [4] = '{8'h02, 8'h08, 8'h02, 8'h20};
  localparam logic [3:0] PS [4] = '{4'd0, 4'd2, 4'd6, 4'd7};
  localparam int         CLRB [4] = '{1, 5, 3, 7};

  logic            clk;
  logic            rst;
  logic            wr;
  logic            rd;
  logic            svc_enter;
  logic            svc_exit;
  logic            irq_req;
  logic [7:0]      addr;
  logic [7:0]      wdata;
  logic [7:0]      rdata;
  logic [3:0]      ext_pin;
  logic [3:0]      lo_req;
  logic [3:0]      svc_src;
  logic [3:0]      irq_src;
  logic [1:0]      irq_level;
  logic [NEVT-1:0] hw_evt;
  logic [7:0]      m [256];
  int              errors;
  int              samples_checked;

  interrupt_request_logic #(.MC_CLKS(MC)) u_dut (
    .clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .ext_pin(ext_pin), .hw_evt(hw_evt), .svc_enter(svc_enter), .svc_src(svc_src),
    .svc_exit(svc_exit), .irq_req(irq_req), .irq_src(irq_src), .irq_level(irq_level));

  ext_requester #(.MC(MC)) u_req (.clk(clk), .lo_req(lo_req), .pin(ext_pin));

  always #2.5 clk = ~clk;

  function automatic logic [7:0] mask(logic [7:0] a);
    case (a)
      8'h88, 8'hba, 8'hc0: return 8'hff;
      8'hb8: return 8'h3f;
      8'hbb, 8'hbc, 8'hc2: return 8'h07;
      8'hc1: return 8'hbf;
      8'hc3: return 8'h7f;
      8'hc4: return 8'hb0;
      default: return 8'h00;
    endcase
  endfunction : mask

  // Winner above the active level: highest level, lowest index on ties
  function automatic logic [6:0] expect_irq(int act);
    logic [10:0] fl;
    logic [10:0] en;
    logic [10:0] hi;
    logic [10:0] lo;
    logic [6:0]  r;
    logic [7:0]  f;
    f  = m[8'hc3];
    fl = {f[5] & ~f[6], f[4], |(m[8'hc4] & 8'hb0), m[8'hc0][5], m[8'hc0][1], |f[1:0],
          |f[3:2], m[8'h88][7], m[8'h88][3], m[8'h88][5], m[8'h88][1]};
    en = {m[8'hc2][2:0], m[8'hc0][6], m[8'hc0][2], m[8'hc1][5:0]};
    hi = {m[8'hbb][2:0], m[8'hba][7:0]};
    lo = {m[8'hbc][2:0], m[8'hc0][7], m[8'hc0][3], m[8'hb8][5:0]};
    r  = 7'h00;
    for (int s = NSRC - 1; s >= 0; s--) begin
      if (fl[s] && en[s] && m[8'hc1][7] && int'({hi[s], lo[s]}) > act &&
          (!r[6] || {hi[s], lo[s]} >= r[1:0])) begin
        r = {1'b1, 4'(s), hi[s], lo[s]};
      end
    end
    return r;
  endfunction : expect_irq

  task automatic end_of_test();
    if (errors == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : end_of_test

  task automatic chk_reg(logic [7:0] got, logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t reg got %h exp %h", $time, got, exp);
    end
  endtask : chk_reg

  task automatic chk_irq(logic [6:0] exp);
    logic [6:0] got;
    repeat (3) @(posedge clk);
    #1 got = irq_req ? {irq_req, irq_src, irq_level} : 7'h00;
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t irq got %h exp %h", $time, got, exp);
    end
  endtask : chk_irq

  task automatic wr_reg(logic [7:0] a, logic [7:0] d);
    @(posedge clk);
    wr    <= 1'b1;
    addr  <= a;
    wdata <= d;
    @(posedge clk);
    wr    <= 1'b0;
    m[a] = d & mask(a);
  endtask : wr_reg

  task automatic rd_reg(logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    rd   <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd   <= 1'b0;
    #1 d = rdata;
  endtask : rd_reg

  task automatic wait_bits(logic [7:0] a, logic [7:0] msk, logic [7:0] exp);
    logic [7:0] d;
    for (int i = 0; i < 40; i++) begin
      rd_reg(a, d);
      if ((d & msk) === exp) break;
    end
    chk_reg(d & msk, exp);
    if ((d & msk) !== exp) end_of_test();
  endtask : wait_bits

  task automatic svc(logic ent, logic [3:0] s);
    @(posedge clk);
    svc_enter <= ent;
    svc_exit  <= ~ent;
    svc_src   <= s;
    @(posedge clk);
    svc_enter <= 1'b0;
    svc_exit  <= 1'b0;
    if (ent && s < 4) m[8'h88][CLRB[s]] = 1'b0;
    if (ent && s == 6) m[8'hc0][1] = 1'b0;
    if (ent && s == 7) m[8'hc0][5] = 1'b0;
  endtask : svc

  task automatic pulse_evt(logic [10:0] e);
    @(posedge clk);
    hw_evt <= e;
    @(posedge clk);
    hw_evt <= '0;
    m[8'h88] |= {e[1], 1'b0, e[0], 5'h00};
    m[8'hc3] |= {2'b00, e[7:2]};
    m[8'hc4] |= {e[8], 1'b0, e[10], e[9], 4'h0};
  endtask : pulse_evt

  initial begin
    logic [7:0] d;
    logic [6:0] w;
    clk = 0; rst = 1; wr = 0; rd = 0; addr = '0; wdata = '0; hw_evt = '0;
    svc_enter = 0; svc_exit = 0; svc_src = '0; lo_req = '0;
    errors = 0; samples_checked = 0;
    foreach (m[i]) m[i] = 8'h00;
    d = 8'($urandom(32'h10d0));
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    foreach (AMAP[i]) begin
      rd_reg(AMAP[i], d);
      chk_reg(d, 8'h00);
    end
    // Falling edge on each pin, held after release, cleared by service entry
    wr_reg(8'h88, 8'h05);
    wr_reg(8'hc0, 8'h11);
    for (int i = 0; i < 4; i++) begin
      lo_req[i] <= 1'b1;
      wait_bits(PA[i], PB[i], PB[i]);
      lo_req[i] <= 1'b0;
      repeat (3 * MC) @(posedge clk);
      wait_bits(PA[i], PB[i], PB[i]);
      svc(1'b1, PS[i]);
      svc(1'b0, 4'd0);
      wait_bits(PA[i], PB[i], 8'h00);
    end
    // Level mode: pending tracks the pin and survives service
    wr_reg(8'h88, 8'h00);
    wr_reg(8'hc0, 8'h00);
    wr_reg(8'hc1, 8'h84);
    lo_req <= 4'hf;
    wait_bits(8'h88, 8'h0a, 8'h0a);
    wait_bits(8'hc0, 8'h22, 8'h22);
    chk_irq(7'h48);
    svc(1'b1, 4'd2);
    svc(1'b0, 4'd0);
    wait_bits(8'h88, 8'h0a, 8'h0a);
    chk_irq(7'h48);
    lo_req <= 4'h0;
    wait_bits(8'h88, 8'h0a, 8'h00);
    // Random priorities, enables and flags from software and hardware
    for (int r = 0; r < 24; r++) begin
      wr_reg(8'h88, 8'h05);
      wr_reg(8'hc0, 8'h11 | (8'($urandom) & 8'hcc));
      for (int k = 1; k < 10; k++) begin
        d = 8'($urandom);
        if (k == 6 && r % 4 != 0) d[7] = 1'b1;
        if (k != 5) wr_reg(AMAP[k], d);
      end
      wr_reg(8'h88, 8'h05 | (8'($urandom) & 8'haa));
      wr_reg(8'hc0, m[8'hc0] | (8'($urandom) & 8'h22));
      pulse_evt(11'($urandom));
      foreach (AMAP[i]) begin
        rd_reg(AMAP[i], d);
        chk_reg(d, m[AMAP[i]]);
      end
      w = expect_irq(-1);
      chk_irq(w);
      if (w[6]) begin
        svc(1'b1, w[5:2]);
        chk_irq(expect_irq(int'(w[1:0])));
        svc(1'b0, 4'd0);
        chk_irq(expect_irq(-1));
      end
    end
    end_of_test();
  end
endmodule : tb_top
